// [charger_consts.svh]
// constants for the charge state sequencer
`ifndef CHARGER_CONSTS_SVH
`define CHARGER_CONSTS_SVH
`define TIMER_WIDTH 14
`define TIMER_TERMINAL 14'h3fff
`define TIMER_ZERO 14'h0000
`define CODE_TRICKLE 2'h0
`define CODE_BULK 2'h1
`define CODE_OVER 2'h2
`define CODE_TOPOFF 2'h3
`define ADDR_STATUS 4'h0
`define ADDR_IRQ_STATUS 4'h1
`define ADDR_IRQ_CLEAR 4'h2
`define ADDR_IRQ_ENABLE 4'h3
`define ADDR_TIMER 4'h4
`define ADDR_CONTROL 4'h5
`define IRQ_BITS 3
`define IRQ_START 0
`define IRQ_OVER 1
`define IRQ_SHUTDOWN 2
`define ENABLE_RESET 3'h0
`define CONTROL_RESET 1'h0
`endif

// [charger_pkg.sv]
// types for the charge state sequencer
package charger_pkg;
  typedef enum logic [4:0] {
    st_idle = 5'b0_0001,
    st_trickle = 5'b0_0010,
    st_bulk = 5'b0_0100,
    st_over = 5'b0_1000,
    st_shutdown = 5'b1_0000
  } charge_state_type;
endpackage : charger_pkg

// [sync_two_flop.sv]
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] first_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      first_reg <= '0;
      sync_o <= '0;
    end
    else
    begin
      first_reg <= async_i;
      sync_o <= first_reg;
    end
  end
endmodule : sync_two_flop

// [charge_state_sequencer.sv]
// charge state sequencer with wishbone status and interrupt registers
`timescale 1ns/10ps
`include "charger_consts.svh"
module charge_state_sequencer
  import charger_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic charge_request_i,
  input wire logic low_battery_sense_i,
  input wire logic battery_sense_at_95_i,
  input wire logic battery_current_above_min_i,
  input wire logic supply_good_i,
  input wire logic timer_ramp_i,
  output logic charge_request_o,
  output logic charge_request_oe_o,
  output logic state_code_lsb_o,
  output logic state_code_lsb_oe_o,
  output logic state_code_msb_o,
  output logic state_code_msb_oe_o,
  output logic current_loop_force_high_o,
  output logic voltage_loop_enable_o,
  output logic trickle_current_enable_o,
  output logic voltage_loop_select_o,
  output logic pwm_ramp_enable_o,
  output logic switching_enable_o,
  output logic timer_ramp_enable_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:2] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);
  charge_state_type state_reg;
  charge_state_type state_next;
  logic [5:0] sync_in;
  logic req_s;
  logic low_batt_s;
  logic at_95_s;
  logic above_min_s;
  logic supply_s;
  logic ramp_s;
  logic req_prev_reg;
  logic ramp_prev_reg;
  logic req_edge;
  logic ramp_tick;
  logic [`TIMER_WIDTH-1:0] timer_reg;
  logic timer_done;
  logic [1:0] code_next;
  logic [`IRQ_BITS-1:0] irq_status_reg;
  logic [`IRQ_BITS-1:0] irq_enable_reg;
  logic [`IRQ_BITS-1:0] irq_event;
  logic hold_request_reg;
  logic wb_req;
  logic wb_write;
  logic [31:0] read_value;

  function automatic logic reg_hit(input logic [5:2] adr,
                                   input logic [3:0] sel);
    reg_hit = (wb_adr_i == adr) && sel[0];
  endfunction : reg_hit

  sync_two_flop #(.WIDTH(6)) sync_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({charge_request_i, low_battery_sense_i, battery_sense_at_95_i,
              battery_current_above_min_i, supply_good_i, timer_ramp_i}),
    .sync_o(sync_in)
  );
  assign {req_s, low_batt_s, at_95_s, above_min_s, supply_s, ramp_s} = sync_in;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_prev_reg <= 1'b0;
      ramp_prev_reg <= 1'b0;
    end
    else
    begin
      req_prev_reg <= req_s;
      ramp_prev_reg <= ramp_s;
    end
  end

  assign req_edge = req_s && !req_prev_reg;
  assign ramp_tick = ramp_s && !ramp_prev_reg;
  assign timer_done = (timer_reg == `TIMER_TERMINAL);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      st_idle, st_shutdown:
      begin
        if (req_edge)
          state_next = low_batt_s ? st_trickle : st_bulk;
      end
      st_trickle:
      begin
        if (!low_batt_s)
          state_next = st_bulk;
      end
      st_bulk:
      begin
        if (low_batt_s)
          state_next = st_trickle;
        else if (at_95_s)
          state_next = st_over;
      end
      st_over:
      begin
        if (timer_done)
          state_next = st_shutdown;
      end
      default: state_next = st_idle;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= st_idle;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_reg <= `TIMER_ZERO;
    else if (req_edge)
      timer_reg <= `TIMER_ZERO;
    else if (state_reg == st_over && ramp_tick && !timer_done)
      timer_reg <= timer_reg + 1'b1;
  end

  always_comb
  begin
    case (state_next)
      st_trickle: code_next = `CODE_TRICKLE;
      st_bulk: code_next = `CODE_BULK;
      st_over: code_next = above_min_s ? `CODE_TOPOFF : `CODE_OVER;
      default: code_next = `CODE_TRICKLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_code_lsb_o <= 1'b0;
      state_code_lsb_oe_o <= 1'b1;
      state_code_msb_o <= 1'b0;
      state_code_msb_oe_o <= 1'b1;
    end
    else
    begin
      // open drain pulls low for zero
      state_code_lsb_o <= 1'b0;
      state_code_msb_o <= 1'b0;
      state_code_lsb_oe_o <= !code_next[0];
      state_code_msb_oe_o <= !code_next[1];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      charge_request_o <= 1'b0;
      charge_request_oe_o <= 1'b0;
      current_loop_force_high_o <= 1'b0;
    end
    else
    begin
      charge_request_o <= 1'b0;
      charge_request_oe_o <= (state_next == st_shutdown) || hold_request_reg;
      current_loop_force_high_o <= (state_next == st_shutdown);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      voltage_loop_enable_o <= 1'b0;
      trickle_current_enable_o <= 1'b0;
      voltage_loop_select_o <= 1'b0;
    end
    else
    begin
      voltage_loop_enable_o <= (state_next != st_trickle);
      trickle_current_enable_o <= (state_next == st_trickle);
      voltage_loop_select_o <= (state_next == st_over);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_ramp_enable_o <= 1'b0;
      switching_enable_o <= 1'b0;
      timer_ramp_enable_o <= 1'b0;
    end
    else
    begin
      pwm_ramp_enable_o <= (state_next != st_idle)
                           && (state_next != st_shutdown);
      switching_enable_o <= supply_s && (state_next != st_idle)
                            && (state_next != st_shutdown);
      timer_ramp_enable_o <= (state_next == st_over);
    end
  end

  // interrupt events: start, overcharge entry, shutdown entry
  assign irq_event[`IRQ_START] = req_edge;
  assign irq_event[`IRQ_OVER] = (state_next == st_over)
                                && (state_reg != st_over);
  assign irq_event[`IRQ_SHUTDOWN] = (state_next == st_shutdown)
                                    && (state_reg != st_shutdown);

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge where the master sees ack
  assign wb_write = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_status_reg <= '0;
    else if (wb_write && reg_hit(`ADDR_IRQ_CLEAR, wb_sel_i))
      irq_status_reg <= (irq_status_reg & ~wb_dat_i[`IRQ_BITS-1:0])
                        | irq_event;
    else
      irq_status_reg <= irq_status_reg | irq_event;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_enable_reg <= `ENABLE_RESET;
      hold_request_reg <= `CONTROL_RESET;
    end
    else if (wb_write && reg_hit(`ADDR_IRQ_ENABLE, wb_sel_i))
      irq_enable_reg <= wb_dat_i[`IRQ_BITS-1:0];
    else if (wb_write && reg_hit(`ADDR_CONTROL, wb_sel_i))
      hold_request_reg <= wb_dat_i[0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_status_reg & irq_enable_reg);
  end

  always_comb
  begin
    read_value = 32'h0000_0000;
    case (wb_adr_i)
      `ADDR_STATUS: read_value = {22'h00_0000, state_reg,
                                  !state_code_msb_oe_o, !state_code_lsb_oe_o,
                                  supply_s, low_batt_s, at_95_s};
      `ADDR_IRQ_STATUS: read_value = {29'h0000_0000, irq_status_reg};
      `ADDR_IRQ_ENABLE: read_value = {29'h0000_0000, irq_enable_reg};
      `ADDR_TIMER: read_value = {18'h0_0000, timer_reg};
      `ADDR_CONTROL: read_value = {31'h0000_0000, hold_request_reg};
      default: read_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? read_value : 32'h0000_0000;
    end
  end
endmodule : charge_state_sequencer

// [cs_sva.sv]
// assertion checker for the charge state sequencer
`timescale 1ns/10ps
module cs_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic charge_request_i,
  input wire logic supply_good_i,
  input wire logic charge_request_oe_o,
  input wire logic state_code_lsb_oe_o,
  input wire logic state_code_msb_oe_o,
  input wire logic current_loop_force_high_o,
  input wire logic voltage_loop_enable_o,
  input wire logic trickle_current_enable_o,
  input wire logic voltage_loop_select_o,
  input wire logic pwm_ramp_enable_o,
  input wire logic switching_enable_o,
  input wire logic timer_ramp_enable_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_SD_PIN: assert property (
    current_loop_force_high_o |-> charge_request_oe_o) else $error("pin");
  AST_SD_GATE: assert property (
    current_loop_force_high_o |-> !switching_enable_o) else $error("gate");
  AST_LOCKOUT: assert property (
    !supply_good_i [*4] |-> !switching_enable_o) else $error("lockout");
  AST_PWM_EDGE: assert property (
    $rose(pwm_ramp_enable_o) |-> $past(charge_request_i, 3))
    else $error("pwm start");
  AST_TRICKLE: assert property (
    trickle_current_enable_o |-> !voltage_loop_enable_o
    && state_code_lsb_oe_o && state_code_msb_oe_o) else $error("trickle");
  AST_VSEL: assert property (
    voltage_loop_select_o |-> !state_code_msb_oe_o) else $error("vsel");
  AST_RAMP: assert property (
    timer_ramp_enable_o |-> voltage_loop_select_o) else $error("ramp");
  AST_ACK: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack");
  C_OVER: cover property (timer_ramp_enable_o);
  C_TRICKLE: cover property (trickle_current_enable_o);
  C_BUS: cover property (wb_ack_o);
  C_SHUT: cover property (current_loop_force_high_o);
endmodule : cs_sva

// [ps_model.sv]
// slow ramp oscillator of the power stage
`timescale 1ns/10ps
module ps_model (
  input wire logic clk_i,
  input wire logic ramp_en_i,
  output logic ramp_o
);
  logic [1:0] cnt;
  initial cnt = 2'h0;
  initial ramp_o = 1'b0;
  always @(posedge clk_i)
  begin
    if (ramp_en_i)
    begin
      cnt <= cnt + 2'h1;
      // toggles every second clock so a full count fits the run
      if (cnt[0])
        ramp_o <= !ramp_o;
    end
  end
endmodule : ps_model

// [charge_state_sequencer_bench.sv]
// self-checking bench for the charge state sequencer
`timescale 1ns/10ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
  n_errors++; $display("ERROR %s exp %h got %h", n, e, a); end end
module charge_state_sequencer_bench;
  logic clk = 0, rst = 1, req = 0, lowb = 0, at95 = 0, curm = 0, supg = 0;
  logic push = 0;
  logic cyc = 0, stb = 0, we = 0, ramp, ack, irq, roe, loe, moe, frc;
  logic vle, tce, vsel, pwm, swe, tre;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rdo, rd;
  int n_errors = 0, tests_run = 0, cyc_n = 0;
  charge_state_sequencer i_dut (.clk_i(clk), .rst_i(rst),
    .charge_request_i(push | (req & !roe)), .low_battery_sense_i(lowb),
    .battery_sense_at_95_i(at95), .battery_current_above_min_i(curm),
    .supply_good_i(supg), .timer_ramp_i(ramp), .charge_request_o(),
    .charge_request_oe_o(roe), .state_code_lsb_o(),
    .state_code_lsb_oe_o(loe), .state_code_msb_o(),
    .state_code_msb_oe_o(moe), .current_loop_force_high_o(frc),
    .voltage_loop_enable_o(vle), .trickle_current_enable_o(tce),
    .voltage_loop_select_o(vsel), .pwm_ramp_enable_o(pwm),
    .switching_enable_o(swe), .timer_ramp_enable_o(tre),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wd), .wb_sel_i(4'hf), .wb_dat_o(rdo), .wb_ack_o(ack),
    .irq_o(irq));
  ps_model i_ps (.clk_i(clk), .ramp_en_i(tre), .ramp_o(ramp));
  initial forever #5 clk = !clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    tick(1);
  endtask : wb
  task automatic summarize;
    $display("tests_run %0d n_errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 90000)
    begin
      n_errors++;
      summarize();
    end
  end
  task automatic t_reset;
    `CHK("pwm", 1'b0, pwm)
    `CHK("code", 2'h3, {moe, loe})
    wb(0, 4'h3, 0);
    `CHK("enable", 32'h0000_0000, rd)
    wb(0, 4'hf, 0);
    `CHK("unmapped", 32'h0000_0000, rd)
    $display("test reset done");
  endtask : t_reset
  task automatic t_bulk;
    supg <= 1'b1;
    req <= 1'b1;
    tick(8);
    `CHK("pwm", 1'b1, pwm)
    `CHK("switch", 1'b1, swe)
    `CHK("code", 2'h2, {moe, loe})
    wb(0, 4'h0, 0);
    `CHK("status code", 2'h1, rd[4:3])
    `CHK("irq masked", 1'b0, irq)
    wb(1, 4'h3, 1);
    tick(2);
    `CHK("irq", 1'b1, irq)
    wb(1, 4'h2, 1);
    tick(2);
    `CHK("irq clear", 1'b0, irq)
    $display("test bulk done");
  endtask : t_bulk
  task automatic t_trickle;
    lowb <= 1'b1;
    tick(8);
    `CHK("trickle", 2'h2, {tce, vle})
    `CHK("code", 2'h3, {moe, loe})
    lowb <= 1'b0;
    supg <= 1'b0;
    tick(8);
    `CHK("lockout", 2'h2, {pwm, swe})
    supg <= 1'b1;
    $display("test trickle done");
  endtask : t_trickle
  task automatic t_over;
    at95 <= 1'b1;
    tick(8);
    `CHK("over", 3'h7, {vsel, tre, loe})
    curm <= 1'b1;
    tick(8);
    `CHK("topoff", 2'h0, {moe, loe})
    tick(200);
    wb(0, 4'h4, 0);
    `CHK("count", 1'b1, rd[13:0] > 14'h0010)
    wb(1, 4'h5, 1);
    tick(1);
    `CHK("pin low", 1'b1, roe)
    wb(1, 4'h5, 0);
    tick(4);
    wb(0, 4'h4, 0);
    `CHK("restart", 1'b1, rd[13:0] < 14'h0004)
    `CHK("kept", 1'b1, vsel)
    $display("test over done");
  endtask : t_over
  task automatic t_shutdown;
    while (frc !== 1'b1)
      tick(1);
    `CHK("shut pin", 2'h3, {roe, frc})
    `CHK("shut gate", 2'h0, {pwm, swe})
    wb(0, 4'h4, 0);
    `CHK("terminal", 14'h3fff, rd[13:0])
    wb(0, 4'h1, 0);
    `CHK("shut irq", 3'h7, rd[2:0])
    lowb <= 1'b1;
    at95 <= 1'b0;
    tick(8);
    `CHK("held", 3'h4, {frc, tce, tre})
    lowb <= 1'b0;
    push <= 1'b1;
    tick(8);
    `CHK("restart", 3'h4, {pwm, frc, roe})
    wb(0, 4'h4, 0);
    `CHK("cleared", 14'h0000, rd[13:0])
    push <= 1'b0;
    $display("test shutdown done");
  endtask : t_shutdown
  initial
  begin
    tick(5);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_bulk();
    t_trickle();
    t_over();
    t_shutdown();
    summarize();
  end
endmodule : charge_state_sequencer_bench
bind charge_state_sequencer cs_sva i_sva (.*);
